// ### hdl/timer_gate_async_counter.v
// gated 16-bit counter with gate source mux, toggle mode and apb registers
// What this block does
// - oscillator enable starts crystal, runs in sleep
// - async select skips the extra external clock sync stage
// - async counter runs in sleep, overflow wakes
// - mode switch may lose or add one increment
// - byte reads while counting async are valid
// - gate enable makes counting depend on gate
// - active gate counts rising edges, inactive holds
// - gate active when level equals polarity bit
// - two-bit select picks pin, t0, t2, watchdog
// - eight-bit timer rollover gives gate pulse
// - period match reset gives gate pulse
// - gate enable with watchdog source powers watchdog
// - watchdog prescaler bits still set interval
// - gating power gives no watchdog reset or wake
// - toggle flip-flop flips on each source rising edge
// - toggle flip-flop held zero while mode off
// - sixteen-bit count, byte writes load directly
// - counter off unless on bit set
//
// Implementation choices: the APB register port and the register offsets.
`timescale 1ns/10ps
`include "timer_gate_map.vh"

module timer_gate_async_counter #(
   parameter WIDTH = 16
) (
   // clock and reset
   input wire clock,
   input wire reset,
   // apb slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // clock and gate sources
   input wire externalClockPin,
   input wire gatePin,
   input wire eightBitTimerOverflow,
   input wire periodMatchTimerReset,
   input wire watchdogOverflow,
   input wire sleepMode,
   // power and wake controls
   output reg lowPowerOscEnable,
   output reg watchdogPowerOn,
   output reg watchdogResetEnable,
   output reg watchdogPrescalerAssign,
   output reg [2:0] watchdogPrescalerRate,
   output reg overflowWake,
   output reg [WIDTH-1:0] countValue
);

   // ****************************************
   // control registers
   // ****************************************
   reg [7:0] counterControlReg_q;
   reg [7:0] gateControlReg_q;
   reg [7:0] watchdogReg_q;
   reg [WIDTH-1:0] count_q;
   reg [WIDTH-1:0] count_d;
   reg overflowFlag_q;

   wire counterOn = counterControlReg_q[`CTRL_ON];
   wire asyncCountSelect = counterControlReg_q[`CTRL_ASYNC];
   wire gateEnable = gateControlReg_q[`GATE_EN];
   wire gatePolarity = gateControlReg_q[`GATE_POL];
   wire gateToggleEnable = gateControlReg_q[`GATE_TOGGLE];
   wire [1:0] gateSourceSelect = gateControlReg_q[`GATE_SRC_HI:`GATE_SRC_LO];
   wire watchdogFuse = watchdogReg_q[`WD_FUSE];

   // ****************************************
   // source synchronisers
   // ****************************************
   // first stage feeds only the second; the async edge is taken from the second and third, the sync edge from the third and a delay stage
   reg [4:0] syncA_q;
   reg [4:0] syncB_q;
   reg [4:0] syncC_q;
   wire [4:0] rawSources = {watchdogOverflow, periodMatchTimerReset, eightBitTimerOverflow,
      gatePin, externalClockPin};

   genvar gi;
   generate
      for (gi = 0; gi < 5; gi = gi + 1) begin : gSync
         always @(posedge clock) begin
            if (reset) begin
               syncA_q[gi] <= 1'b0;
               syncB_q[gi] <= 1'b0;
               syncC_q[gi] <= 1'b0;
            end else begin
               syncA_q[gi] <= rawSources[gi];
               syncB_q[gi] <= syncA_q[gi];
               syncC_q[gi] <= syncB_q[gi];
            end
         end
      end
   endgenerate

   // ****************************************
   // external clock edge detection
   // ****************************************
   // async mode skips the extra stage; sync mode adds one, so a switch can slip one edge
   reg extDelay_q;
   always @(posedge clock) begin
      if (reset) begin
         extDelay_q <= 1'b0;
      end else begin
         extDelay_q <= syncC_q[0];
      end
   end
   wire asyncEdge = syncB_q[0] & ~syncC_q[0];
   wire syncEdge = syncC_q[0] & ~extDelay_q;
   wire countTick = asyncCountSelect ? asyncEdge : syncEdge;

   // ****************************************
   // gate source select and toggle
   // ****************************************
   reg gateSource;
   always @* begin
      case (gateSourceSelect)
         `SRC_PIN: gateSource = syncB_q[1];
         `SRC_T0: gateSource = syncB_q[2];
         `SRC_T2: gateSource = syncB_q[3];
         default: gateSource = syncB_q[4];
      endcase
   end

   // previous level of the selected source, so each pulse flips the toggle once
   reg gateSourcePrev_q;
   reg gateToggle_q;
   always @(posedge clock) begin
      if (reset) begin
         gateSourcePrev_q <= 1'b0;
         gateToggle_q <= 1'b0;
      end else begin
         gateSourcePrev_q <= gateSource;
         if (!gateToggleEnable) begin
            gateToggle_q <= 1'b0;
         end else if (gateSource & ~gateSourcePrev_q) begin
            gateToggle_q <= ~gateToggle_q;
         end
      end
   end

   wire gateLevel = gateToggleEnable ? gateToggle_q : gateSource;
   wire gateActive = (gateLevel == gatePolarity);
   wire countEnable = counterOn & (~gateEnable | gateActive);

   // ****************************************
   // apb access decode
   // ****************************************
   // a write lands only when pready is up, at the last edge of the access phase
   wire access = psel & penable;
   wire wrStrobe = access & pwrite & pready;

   // address hits, one per register; no hit gives an error answer and drops the write
   wire hitCtrl = (paddr == `ADDR_CTRL);
   wire hitGate = (paddr == `ADDR_GATE);
   wire hitCntLo = (paddr == `ADDR_CNT_LO);
   wire hitCntHi = (paddr == `ADDR_CNT_HI);
   wire hitWdog = (paddr == `ADDR_WDOG);
   wire hitStatus = (paddr == `ADDR_STATUS);
   wire known = hitCtrl | hitGate | hitCntLo | hitCntHi | hitWdog | hitStatus;

   // one write enable per register
   wire wrCtrl = wrStrobe & hitCtrl;
   wire wrGate = wrStrobe & hitGate;
   wire wrCntLo = wrStrobe & hitCntLo;
   wire wrCntHi = wrStrobe & hitCntHi;
   wire wrWdog = wrStrobe & hitWdog;
   wire wrStatus = wrStrobe & hitStatus;

   // ****************************************
   // counter next value
   // ****************************************
   // a count write beats a coinciding tick, so no rollover is flagged for a step never taken
   wire countIncrement = countEnable & countTick & ~wrCntLo & ~wrCntHi;
   wire countRollOver = countIncrement & (&count_q);

   // next count: a byte load or a single step; software should stop the counter before a load
   always @* begin
      count_d = count_q;
      if (wrCntLo) begin
         count_d[7:0] = pwdata[7:0];
      end else if (wrCntHi) begin
         count_d[WIDTH-1:8] = pwdata[WIDTH-9:0];
      end else if (countIncrement) begin
         count_d = count_q + {{(WIDTH-1){1'b0}}, 1'b1};
      end
   end

   // ****************************************
   // counter and overflow flag
   // ****************************************
   // the counter register, loaded every edge from its next value
   always @(posedge clock) begin
      if (reset) begin
         count_q <= {WIDTH{1'b0}};
      end else begin
         count_q <= count_d;
      end
   end

   // sticky overflow; the set wins over a clear in the same cycle so no rollover is lost
   always @(posedge clock) begin
      if (reset) begin
         overflowFlag_q <= 1'b0;
      end else if (countRollOver) begin
         overflowFlag_q <= 1'b1;
      end else if (wrStatus && pwdata[0]) begin
         overflowFlag_q <= 1'b0;
      end
   end

   // ****************************************
   // register writes
   // ****************************************
   // counter control: on, async select and oscillator enable
   always @(posedge clock) begin
      if (reset) begin
         counterControlReg_q <= `CTRL_RESET;
      end else if (wrCtrl) begin
         counterControlReg_q <= pwdata[7:0];
      end
   end

   // gate control; polarity and toggle must not change in one write, the result is undefined
   always @(posedge clock) begin
      if (reset) begin
         gateControlReg_q <= `GATE_RESET;
      end else if (wrGate) begin
         gateControlReg_q <= pwdata[7:0];
      end
   end

   // watchdog settings: rate, prescaler assignment and fuse; the fuse comes out of reset set
   always @(posedge clock) begin
      if (reset) begin
         watchdogReg_q <= `WD_RESET;
      end else if (wrWdog) begin
         watchdogReg_q <= pwdata[7:0];
      end
   end

   // ****************************************
   // apb answer
   // ****************************************
   // status bits: overflow flag, toggle flip-flop and live gate value
   wire [31:0] statusWord = {29'h0000000, gateActive, gateToggle_q, overflowFlag_q};

   // read mux over the live registers; count bytes come straight from the counter
   reg [31:0] readData;
   always @* begin
      readData = 32'h00000000;
      case (paddr)
         `ADDR_CTRL: readData = {24'h000000, counterControlReg_q};
         `ADDR_GATE: readData = {24'h000000, gateControlReg_q};
         `ADDR_CNT_LO: readData = {24'h000000, count_q[7:0]};
         `ADDR_CNT_HI: readData = {24'h000000, count_q[WIDTH-1:8]};
         `ADDR_WDOG: readData = {24'h000000, watchdogReg_q};
         `ADDR_STATUS: readData = statusWord;
         default: readData = 32'h00000000;
      endcase
   end

   // one wait state: ready rises in the second access cycle and never later
   always @(posedge clock) begin
      if (reset) begin
         pready <= 1'b0;
      end else begin
         pready <= access & ~pready;
      end
   end

   // error answer on an unmapped address, raised together with ready
   always @(posedge clock) begin
      if (reset) begin
         pslverr <= 1'b0;
      end else begin
         pslverr <= access & ~pready & ~known;
      end
   end

   // read data stands for the ready cycle only and is zero otherwise
   always @(posedge clock) begin
      if (reset) begin
         prdata <= 32'h00000000;
      end else if (access && !pready && !pwrite) begin
         prdata <= readData;
      end else begin
         prdata <= 32'h00000000;
      end
   end

   // ****************************************
   // power, watchdog and wake outputs
   // ****************************************
   // gating powers the watchdog but leaves its reset and wake under the fuse alone
   wire watchdogGateSelected = gateEnable & (gateSourceSelect == `SRC_WDOG);

   // watchdog controls; in reset the prescaler assignment and rate follow the watchdog register's reset value, power and reset enable are held low
   always @(posedge clock) begin
      if (reset) begin
         watchdogPowerOn <= 1'b0;
         watchdogResetEnable <= 1'b0;
         watchdogPrescalerAssign <= 1'b1;
         watchdogPrescalerRate <= 3'h7;
      end else begin
         watchdogPowerOn <= watchdogFuse | watchdogGateSelected;
         watchdogResetEnable <= watchdogFuse;
         watchdogPrescalerAssign <= watchdogReg_q[`WD_ASSIGN];
         watchdogPrescalerRate <= watchdogReg_q[`WD_RATE_HI:`WD_RATE_LO];
      end
   end

   // oscillator enable passes straight through; the start-up wait is left to software
   always @(posedge clock) begin
      if (reset) begin
         lowPowerOscEnable <= 1'b0;
      end else begin
         lowPowerOscEnable <= counterControlReg_q[`CTRL_OSC];
      end
   end

   // wake needs sleep and async counting; a synchronised counter cannot run while asleep
   always @(posedge clock) begin
      if (reset) begin
         overflowWake <= 1'b0;
      end else begin
         overflowWake <= overflowFlag_q & sleepMode & asyncCountSelect;
      end
   end

   // count output is taken from the next value so it tracks the counter with no lag
   always @(posedge clock) begin
      if (reset) begin
         countValue <= {WIDTH{1'b0}};
      end else begin
         countValue <= count_d;
      end
   end

endmodule

// ### hdl/timer_gate_map.vh
// register offsets, field positions and reset values of the gated counter
`ifndef TIMER_GATE_MAP_VH
`define TIMER_GATE_MAP_VH
// ****************************************
// register byte addresses
// ****************************************
`define ADDR_CTRL 12'h000
`define ADDR_GATE 12'h004
`define ADDR_CNT_LO 12'h008
`define ADDR_CNT_HI 12'h00C
`define ADDR_WDOG 12'h010
`define ADDR_STATUS 12'h014
// ****************************************
// counter control fields
// ****************************************
`define CTRL_ON 0
`define CTRL_ASYNC 2
`define CTRL_OSC 3
// ****************************************
// gate control fields
// ****************************************
`define GATE_SRC_LO 0
`define GATE_SRC_HI 1
`define GATE_TOGGLE 5
`define GATE_POL 6
`define GATE_EN 7
// ****************************************
// watchdog control fields
// ****************************************
`define WD_RATE_LO 0
`define WD_RATE_HI 2
`define WD_ASSIGN 3
`define WD_FUSE 4
// ****************************************
// gate source codes and reset values
// ****************************************
`define SRC_PIN 2'h0
`define SRC_T0 2'h1
`define SRC_T2 2'h2
`define SRC_WDOG 2'h3
`define CTRL_RESET 8'h00
`define GATE_RESET 8'h00
`define WD_RESET 8'h1F
`endif

// ### verification/ext_clock_model.sv
// burst model of the external counting clock pin
`timescale 1ns/10ps
module ext_clock_model (
   // clock and reset
   input wire clock,
   input wire reset,
   // burst request: number of rising edges and half period in cycles less one
   input wire start,
   input wire [3:0] edges,
   input wire [2:0] half,
   // pin and status
   output reg externalClockPin,
   output reg busy
);
   reg [3:0] left;
   reg [2:0] phase;
   // pin rests low between bursts, so a low is always seen before the first rise
   always @(posedge clock) begin
      if (reset) begin
         externalClockPin <= 1'h0;
         busy <= 1'h0;
      end else if (start && !busy) begin
         left <= edges;
         phase <= half;
         busy <= edges != 4'h0;
      end else if (busy && phase != 3'h0) begin
         phase <= phase - 3'h1;
      end else if (busy) begin
         phase <= half;
         externalClockPin <= !externalClockPin;
         busy <= !(externalClockPin && left == 4'h1);
         left <= left - {3'h0, externalClockPin};
      end
   end
endmodule

// ### verification/timer_gate_checker_sva.sv
// port checker of the gated counter
`timescale 1ns/10ps
`include "timer_gate_map.vh"
module timer_gate_checker #(parameter WIDTH = 16) (
   // clock and reset
   input wire clock,
   input wire reset,
   // apb
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire pready,
   input wire pslverr,
   // pins and outputs
   input wire gatePin,
   input wire sleepMode,
   input wire watchdogPowerOn,
   input wire watchdogResetEnable,
   input wire overflowWake,
   input wire [WIDTH-1:0] countValue
);
   default clocking @(posedge clock); endclocking
   default disable iff (reset);
   wire wr = psel && penable && pready && pwrite;
   wire bad = paddr > `ADDR_STATUS || paddr[1:0] != 2'h0;
   reg on, fuse;
   reg [7:0] gate;
   reg [3:0] age, offCnt, holdCnt;
   // shadow of written settings; quiet counters restart on any write, since a write may move the count
   always @(posedge clock) begin
      if (reset) begin
         {on, fuse, gate} <= 10'h100;
         {age, offCnt, holdCnt} <= 12'h000;
      end else begin
         if (wr && !bad && paddr == `ADDR_CTRL) on <= pwdata[0];
         if (wr && !bad && paddr == `ADDR_GATE) gate <= pwdata[7:0];
         if (wr && !bad && paddr == `ADDR_WDOG) fuse <= pwdata[4];
         age <= wr ? 4'h0 : age + {3'h0, age != 4'hF};
         offCnt <= (wr || on) ? 4'h0 : offCnt + {3'h0, offCnt != 4'hF};
         holdCnt <= (wr || gate[5:0] != 6'h00 || !gate[7] || gatePin == gate[6]) ? 4'h0 :
            holdCnt + {3'h0, holdCnt != 4'hF};
      end
   end
   a_ready_wait: assert property (psel && $rose(penable) |-> !pready ##1 pready)
      else $error("ready not on second access cycle");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   a_error_map: assert property (pready |-> pslverr == bad)
      else $error("error response wrong");
   a_wdog_power: assert property (age > 4'h3 |->
      watchdogPowerOn == (fuse || gate[7] && gate[1:0] == 2'h3) && watchdogResetEnable == fuse)
      else $error("watchdog power wrong");
   a_count_step: assert property (!$stable(countValue) |->
      countValue == $past(countValue) + 1'h1 || $past(wr) || $past(wr, 2))
      else $error("count jumped");
   a_off_hold: assert property (offCnt > 4'h5 |-> $stable(countValue))
      else $error("count moved while off");
   a_gate_hold: assert property (holdCnt > 4'h7 |-> $stable(countValue))
      else $error("count moved with gate inactive");
   a_wake_sleep: assert property (overflowWake |-> $past(sleepMode))
      else $error("wake outside sleep");
   c_gate_hold: cover property (holdCnt == 4'hF);
   c_count_load: cover property (wr && paddr == `ADDR_CNT_LO);
   c_wake: cover property (overflowWake);
endmodule

// ### verification/testbench.sv
// self-checking bench of the gated counter
`timescale 1ns/10ps
`include "timer_gate_map.vh"
module testbench;
   logic clock = 1'h0, reset = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, start = 1'h0;
   logic sleepMode = 1'h0, gatePin = 1'h0, eightBitTimerOverflow = 1'h0, periodMatchTimerReset = 1'h0;
   logic watchdogOverflow = 1'h0, externalClockPin, busy, pready, pslverr, lowPowerOscEnable, overflowWake;
   logic watchdogPowerOn, watchdogResetEnable, watchdogPrescalerAssign;
   logic [2:0] half = 3'h2, watchdogPrescalerRate;
   logic [3:0] edges = 4'h0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata;
   logic [15:0] countValue;
   logic [64:0] expQ[$], note;
   int error_cnt = 0, samples_checked = 0;
   timer_gate_async_counter i_timer_gate_async_counter (.clock, .reset, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .externalClockPin, .gatePin, .eightBitTimerOverflow,
      .periodMatchTimerReset, .watchdogOverflow, .sleepMode, .lowPowerOscEnable, .watchdogPowerOn,
      .watchdogResetEnable, .watchdogPrescalerAssign, .watchdogPrescalerRate, .overflowWake, .countValue);
   ext_clock_model i_ext_clock_model (.clock, .reset, .start, .edges, .half, .externalClockPin, .busy);
   // bench clock
   initial forever #5 clock = ~clock;
   task automatic check(input string name, input logic [31:0] seen, exp);
      samples_checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic hang;
      check("wait", 1'h0, 1'h1);
      summarize();
   endtask
   // one transfer held until pready; its expected answer is queued for the monitor
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, m);
      int k;
      expQ.push_back({a > `ADDR_STATUS || a[1:0] != 2'h0, m, d});
      {psel, pwrite, paddr, pwdata} <= {1'h1, wr, a, wr ? d : 32'h0};
      @(posedge clock);
      penable <= 1'h1;
      k = 0;
      do begin
         @(posedge clock);
         k++;
      end while (pready !== 1'h1 && k < 20);
      if (pready !== 1'h1) hang();
      {psel, penable} <= 2'h0;
      @(posedge clock);
   endtask
   // n rising edges on the external pin, then room for the synchroniser latency
   task automatic burst(input logic [3:0] n);
      int k;
      {start, edges} <= {1'h1, n};
      @(posedge clock);
      start <= 1'h0;
      k = 0;
      do begin
         @(posedge clock);
         k++;
      end while (busy && k < 300);
      if (busy) hang();
      repeat (8) @(posedge clock);
   endtask
   // load a random low byte with the counter stopped, count a burst, stop, read back
   task automatic measure(input logic [7:0] ctrl, gate, input logic [3:0] n, input logic [7:0] inc);
      logic [7:0] base;
      base = 8'($urandom % 256);
      apb(1'h1, `ADDR_CTRL, {24'h0, ctrl}, 32'h0);
      apb(1'h1, `ADDR_GATE, {24'h0, gate}, 32'h0);
      apb(1'h1, `ADDR_CNT_LO, {24'h0, base}, 32'h0);
      apb(1'h1, `ADDR_CNT_HI, 32'h0, 32'h0);
      apb(1'h1, `ADDR_CTRL, {24'h0, ctrl | 8'h01}, 32'h0);
      burst(n);
      apb(1'h1, `ADDR_CTRL, {24'h0, ctrl}, 32'h0);
      apb(1'h0, `ADDR_CNT_LO, {24'h0, base + inc}, 32'hFF);
   endtask
   // one watchdog time-out pulse as gate source
   task automatic pulse;
      watchdogOverflow <= 1'h1;
      repeat (4) @(posedge clock);
      watchdogOverflow <= 1'h0;
      repeat (4) @(posedge clock);
   endtask
   // compares each finished transfer with the oldest note
   always @(posedge clock) begin
      if (psel && penable && pready === 1'h1) begin
         note = expQ.pop_front();
         check("pslverr", {31'h0, pslverr}, {31'h0, note[64]});
         check("prdata", prdata & note[63:32], note[31:0] & note[63:32]);
      end
   end
   initial begin
      logic [3:0] n;
      logic [2:0] sel;
      void'($urandom(1031));
      repeat (20) @(posedge clock);
      reset <= 1'h0;
      repeat (2) @(posedge clock);
      check("wdog", {watchdogPowerOn, watchdogResetEnable, watchdogPrescalerAssign, watchdogPrescalerRate}, 6'h3F);
      apb(1'h0, `ADDR_WDOG, 32'h1F, 32'hFF);
      apb(1'h0, 12'h018, 32'h0, 32'hFFFFFFFF);
      apb(1'h1, `ADDR_WDOG, 32'h05, 32'h0);
      apb(1'h1, `ADDR_GATE, 32'h83, 32'h0);
      apb(1'h1, `ADDR_CTRL, 32'h08, 32'h0);
      repeat (3) @(posedge clock);
      check("wdog", {watchdogPowerOn, watchdogResetEnable, watchdogPrescalerAssign, watchdogPrescalerRate}, 6'h25);
      check("osc", lowPowerOscEnable, 1'h1);
      measure(8'h04, 8'h00, 4'h6, 8'h06);
      for (int s = 0; s < 4; s++)
         for (int p = 0; p < 2; p++)
            for (int l = 0; l < 2; l++) begin
               n = 4'(1 + $urandom % 7);
               sel = 3'(4'h1 << s >> 1);
               half <= 3'(2 + $urandom % 4);
               gatePin <= (s == 0) ? l[0] : !l[0];
               {watchdogOverflow, periodMatchTimerReset, eightBitTimerOverflow} <= l[0] ? sel : ~sel;
               measure(8'h00, 8'(8'h80 | p << 6 | s), n, (l == p) ? 8'(n) : 8'h00);
            end
      {gatePin, watchdogOverflow, periodMatchTimerReset, eightBitTimerOverflow} <= 4'h0;
      apb(1'h1, `ADDR_GATE, 32'hC3, 32'h0);
      apb(1'h1, `ADDR_GATE, 32'hE3, 32'h0);
      pulse();
      measure(8'h00, 8'hE3, 4'h4, 8'h04);
      apb(1'h0, `ADDR_STATUS, 32'h02, 32'h02);
      pulse();
      measure(8'h00, 8'hE3, 4'h4, 8'h00);
      pulse();
      apb(1'h1, `ADDR_GATE, 32'hC0, 32'h0);
      apb(1'h0, `ADDR_STATUS, 32'h00, 32'h02);
      apb(1'h1, `ADDR_GATE, 32'h00, 32'h0);
      apb(1'h1, `ADDR_CNT_LO, 32'hFF, 32'h0);
      apb(1'h1, `ADDR_CNT_HI, 32'hFF, 32'h0);
      apb(1'h1, `ADDR_CTRL, 32'h05, 32'h0);
      sleepMode <= 1'h1;
      burst(4'h1);
      check("wake", overflowWake, 1'h1);
      sleepMode <= 1'h0;
      apb(1'h0, `ADDR_CNT_HI, 32'h00, 32'hFF);
      apb(1'h0, `ADDR_STATUS, 32'h01, 32'h01);
      apb(1'h1, `ADDR_STATUS, 32'h01, 32'h0);
      apb(1'h0, `ADDR_STATUS, 32'h00, 32'h01);
      summarize();
   end
endmodule
bind timer_gate_async_counter timer_gate_checker #(.WIDTH(WIDTH)) i_timer_gate_checker (.clock, .reset, .psel,
   .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .gatePin, .sleepMode, .watchdogPowerOn,
   .watchdogResetEnable, .overflowWake, .countValue);
